/* exec_pkg.sv */
package exec_pkg;
	localparam int INSN_W = 14;
	localparam int PC_W = 13;
	localparam int DATA_W = 8;
	localparam int FADDR_W = 7;
	localparam int CALL_K_W = 11;
	localparam int STACK_DEPTH = 8;
	localparam int WDT_W = 8;
	localparam int WDT_PRE_W = 8;
	// opcode patterns (14-bit words) and masks
	localparam logic [13:0] OP_MASK_BIT = 14'h3c00;
	localparam logic [13:0] OP_BIT_CLEAR = 14'h1800;
	localparam logic [13:0] OP_BIT_SET = 14'h1c00;
	localparam logic [13:0] OP_MASK_BYTE = 14'h3f00;
	localparam logic [13:0] OP_AND_FILE = 14'h0500;
	localparam logic [13:0] OP_MASK_CLR = 14'h3f80;
	localparam logic [13:0] OP_ZERO_FILE = 14'h0180;
	localparam logic [13:0] OP_ZERO_ACC = 14'h0100;
	localparam logic [13:0] OP_MASK_ALL = 14'h3fff;
	localparam logic [13:0] OP_WDT_RESTART = 14'h0064;
	localparam logic [13:0] OP_MASK_CALL = 14'h3800;
	localparam logic [13:0] OP_CALL = 14'h2000;
	// field positions
	localparam int DEST_POS = 7;
	localparam int BIT_LSB = 7;
	localparam int LATCH_HI = 4;
	localparam int LATCH_LO = 3;
	// status bit positions
	localparam int ST_ZERO = 2;
	localparam int ST_SLEEP = 3;
	localparam int ST_EXPIRY = 4;
	localparam logic [7:0] STATUS_RESET = 8'h18;
	localparam logic [12:0] PC_RESET = 13'h0000;
	typedef enum logic [0:0] {
		ST_EXEC = 1'b0,
		ST_FLUSH = 1'b1
	} cycle_e;
endpackage

/* return_stack.sv */
module return_stack
	import exec_pkg::*;
#(
	parameter int DEPTH = STACK_DEPTH,
	parameter int WIDTH = PC_W
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_push,
	input wire logic [WIDTH-1:0] i_data,
	output logic [WIDTH-1:0] o_stack_top_entry
);
	localparam int PTR_W = $clog2(DEPTH);
	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
			$error("return_stack: DEPTH must be a power of two of at least 2");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] ptr;
	wire [PTR_W-1:0] next_ptr = ptr + PTR_W'(1);
	// circular stack: overflow wraps silently, as the core does
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ptr <= '0;
		end else if (i_push) begin
			ptr <= next_ptr;
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_push) begin
			mem[next_ptr] <= i_data;
		end
	end
	assign o_stack_top_entry = mem[ptr];
endmodule

/* bit_test_call_clear_exec.sv */
// What this block does
// - bit-clear test skips next when bit zero
// - bit-set test skips next when bit one
// - acc AND file, destination bit selects target
// - watchdog restart zeroes count and prescaler
// - watchdog restart sets expiry and sleep bits
// - call pushes pc plus one on stack
// - call loads k low, latch bits high
// - call takes two instruction cycles
// - clear file writes zero, sets zero flag
// - clear accumulator writes zero, sets zero flag
// - pc change or true test adds nop cycle
module bit_test_call_clear_exec
	import exec_pkg::*;
#(
	parameter int DEPTH = STACK_DEPTH
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_insn_valid,
	input wire logic [INSN_W-1:0] i_insn,
	input wire logic [DATA_W-1:0] i_file_rdata,
	input wire logic [DATA_W-1:0] i_upper_program_latch,
	input wire logic i_wdt_tick,
	output logic o_insn_taken,
	output logic [PC_W-1:0] o_pc,
	output logic [DATA_W-1:0] o_acc,
	output logic [DATA_W-1:0] o_status,
	output logic [FADDR_W-1:0] o_file_addr,
	output logic [DATA_W-1:0] o_file_wdata,
	output logic o_file_we,
	output logic o_flush,
	output logic [PC_W-1:0] o_stack_top_entry,
	output logic [WDT_W-1:0] o_watchdog_count,
	output logic [WDT_PRE_W-1:0] o_wdt_prescale
);
	initial begin
		if (DEPTH < 2)
			$error("bit_test_call_clear_exec: DEPTH must be at least 2");
	end

	function automatic logic match(input logic [INSN_W-1:0] insn, input logic [13:0] mask,
		input logic [13:0] pat);
		match = (insn & mask) == pat;
	endfunction

	cycle_e state;
	cycle_e next_state;
	logic [PC_W-1:0] pc;
	logic [DATA_W-1:0] acc;
	logic [DATA_W-1:0] status;
	logic [WDT_W-1:0] wdt;
	logic [WDT_PRE_W-1:0] pre;
	logic [FADDR_W-1:0] faddr;
	logic [DATA_W-1:0] fwdata;
	logic fwe;
	logic taken;
	logic [PC_W-1:0] stack_top_q;
	wire [PC_W-1:0] stack_top;

	// decode: an instruction arriving in a flush cycle is the discarded one
	wire exec_now = i_insn_valid && state == ST_EXEC;
	wire is_bit_clear = exec_now && match(i_insn, OP_MASK_BIT, OP_BIT_CLEAR);
	wire is_bit_set = exec_now && match(i_insn, OP_MASK_BIT, OP_BIT_SET);
	wire is_and_file = exec_now && match(i_insn, OP_MASK_BYTE, OP_AND_FILE);
	wire is_zero_file = exec_now && match(i_insn, OP_MASK_CLR, OP_ZERO_FILE);
	wire is_zero_acc = exec_now && match(i_insn, OP_MASK_CLR, OP_ZERO_ACC);
	wire is_wdt_restart = exec_now && match(i_insn, OP_MASK_ALL, OP_WDT_RESTART);
	wire is_call = exec_now && match(i_insn, OP_MASK_CALL, OP_CALL);

	wire [FADDR_W-1:0] f_field = i_insn[FADDR_W-1:0];
	wire [2:0] bit_sel = i_insn[BIT_LSB+2:BIT_LSB];
	wire dest_file = i_insn[DEST_POS];
	wire tested_bit = i_file_rdata[bit_sel];
	wire skip_clear = is_bit_clear && !tested_bit;
	wire skip_set = is_bit_set && tested_bit;
	wire and_zero_acc_dest = is_and_file && !dest_file;
	wire [DATA_W-1:0] and_result = acc & i_file_rdata;

	// pc plus one is the return address while the call is in its first cycle
	wire [PC_W-1:0] pc_inc = pc + PC_W'(1);
	wire [PC_W-1:0] call_target = {i_upper_program_latch[LATCH_HI:LATCH_LO],
		i_insn[CALL_K_W-1:0]};
	wire advance = i_insn_valid;

	assign next_state = (skip_clear || skip_set || is_call) ? ST_FLUSH : ST_EXEC;

	wire [PC_W-1:0] next_pc = is_call ? call_target : (advance ? pc_inc : pc);

	wire [DATA_W-1:0] next_acc = is_zero_acc ? DATA_W'(0)
		: and_zero_acc_dest ? and_result : acc;

	// zero flag: clears always set it; AND reflects result, others left alone
	wire next_zero = (is_zero_file || is_zero_acc) ? 1'b1
		: is_and_file ? (and_result == '0) : status[ST_ZERO];

	wire next_expiry = is_wdt_restart ? 1'b1 : status[ST_EXPIRY];
	wire next_sleep = is_wdt_restart ? 1'b1 : status[ST_SLEEP];

	logic [DATA_W-1:0] next_status;
	always_comb begin
		next_status = status;
		next_status[ST_ZERO] = next_zero;
		next_status[ST_EXPIRY] = next_expiry;
		next_status[ST_SLEEP] = next_sleep;
	end

	// restart wins over a tick in the same cycle, so the count is really zero afterwards
	wire [WDT_PRE_W-1:0] next_pre = is_wdt_restart ? '0 : (i_wdt_tick ? pre + WDT_PRE_W'(1) : pre);
	wire pre_wrap = i_wdt_tick && (pre == '1);
	wire [WDT_W-1:0] next_wdt = is_wdt_restart ? '0 : (pre_wrap ? wdt + WDT_W'(1) : wdt);

	wire next_fwe = is_zero_file || (is_and_file && dest_file);
	wire [DATA_W-1:0] next_fwdata = is_zero_file ? DATA_W'(0)
		: (is_and_file && dest_file) ? and_result : DATA_W'(0);

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= ST_EXEC;
			pc <= PC_RESET;
			acc <= '0;
			status <= STATUS_RESET;
		end else begin
			state <= next_state;
			pc <= next_pc;
			acc <= next_acc;
			status <= next_status;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wdt <= '0;
			pre <= '0;
		end else begin
			wdt <= next_wdt;
			pre <= next_pre;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			faddr <= '0;
			fwdata <= '0;
			fwe <= 1'b0;
			taken <= 1'b0;
			stack_top_q <= '0;
		end else begin
			faddr <= f_field;
			fwdata <= next_fwdata;
			fwe <= next_fwe;
			taken <= advance;
			stack_top_q <= stack_top;
		end
	end

	return_stack #(
		.DEPTH(DEPTH),
		.WIDTH(PC_W)
	) u_stack (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_push(is_call),
		.i_data(pc_inc),
		.o_stack_top_entry(stack_top)
	);

	assign o_insn_taken = taken;
	assign o_pc = pc;
	assign o_acc = acc;
	assign o_status = status;
	assign o_file_addr = faddr;
	assign o_file_wdata = fwdata;
	assign o_file_we = fwe;
	assign o_flush = state;
	assign o_stack_top_entry = stack_top_q;
	assign o_watchdog_count = wdt;
	assign o_wdt_prescale = pre;
endmodule

/* bit_test_call_clear_exec_asserts.sv */
module bit_test_call_clear_exec_chk
	import exec_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_insn_valid,
	input wire logic [INSN_W-1:0] i_insn,
	input wire logic [DATA_W-1:0] i_file_rdata,
	input wire logic [DATA_W-1:0] i_upper_program_latch,
	input wire logic [PC_W-1:0] o_pc,
	input wire logic [DATA_W-1:0] o_acc,
	input wire logic [DATA_W-1:0] o_status,
	input wire logic [DATA_W-1:0] o_file_wdata,
	input wire logic o_file_we,
	input wire logic o_flush,
	input wire logic [PC_W-1:0] o_stack_top_entry,
	input wire logic [WDT_W-1:0] o_watchdog_count
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	// an instruction in the nop slot is discarded, so it never counts as executed
	wire logic run = i_insn_valid && !o_flush;
	wire logic is_call = run && (i_insn & OP_MASK_CALL) == OP_CALL;
	wire logic is_btc = run && (i_insn & OP_MASK_BIT) == OP_BIT_CLEAR;
	wire logic is_bts = run && (i_insn & OP_MASK_BIT) == OP_BIT_SET;
	wire logic is_and = run && (i_insn & OP_MASK_BYTE) == OP_AND_FILE;
	wire logic is_zero_file_reg_op = run && (i_insn & OP_MASK_CLR) == OP_ZERO_FILE;
	wire logic is_zero_acc_op = run && (i_insn & OP_MASK_CLR) == OP_ZERO_ACC;
	wire logic is_wdr = run && i_insn == OP_WDT_RESTART;
	wire logic tbit = i_file_rdata[i_insn[9:7]];
	wire logic dbit = i_insn[DEST_POS];
	wire logic [PC_W-1:0] target = {i_upper_program_latch[4:3], i_insn[10:0]};
	wire logic [DATA_W-1:0] anded = o_acc & i_file_rdata;
	sequence call_then_nop;
		is_call ##1 o_flush;
	endsequence
	chk_call_target: assert property (is_call |=> o_pc == $past(target)) else $error("call target wrong");
	chk_call_two: assert property (is_call |=> o_flush ##1 !o_flush) else $error("call length wrong");
	chk_call_push: assert property (call_then_nop |=> o_stack_top_entry == $past(o_pc, 2) + 13'h0001)
		else $error("return address wrong");
	chk_skip_clear: assert property (is_btc |=> o_flush == !$past(tbit)) else $error("bit clear skip wrong");
	chk_skip_set: assert property (is_bts |=> o_flush == $past(tbit)) else $error("bit set skip wrong");
	chk_and_result: assert property (is_and |=> o_file_we == $past(dbit) && (o_acc == ($past(dbit) ? $past(o_acc)
		: $past(anded))) && o_status[ST_ZERO] == ($past(anded) == 8'h00)) else $error("and result wrong");
	chk_zero_file: assert property (is_zero_file_reg_op |=> o_file_we && o_file_wdata == 8'h00 && o_status[ST_ZERO])
		else $error("clear file wrong");
	chk_zero_acc: assert property (is_zero_acc_op |=> o_acc == 8'h00 && o_status[ST_ZERO]) else $error("clear acc wrong");
	chk_wdt_restart: assert property (is_wdr |=> o_watchdog_count == 8'h00 && o_status[ST_EXPIRY] && o_status[ST_SLEEP])
		else $error("restart wrong");
endmodule

bind bit_test_call_clear_exec bit_test_call_clear_exec_chk chk (.*);

/* tb_bit_test_call_clear_exec.sv */
module tb_bit_test_call_clear_exec import exec_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_ref_clk = 1'b0, i_rst_n = 1'b0, i_insn_valid = 1'b0, i_wdt_tick = 1'b0;
	logic [13:0] i_insn = 14'h0000;
	logic [7:0] i_file_rdata = 8'h00, i_upper_program_latch = 8'h18;
	logic o_insn_taken, o_file_we, o_flush;
	logic [12:0] o_pc, o_stack_top_entry;
	logic [7:0] o_acc, o_status, o_file_wdata, o_watchdog_count, o_wdt_prescale;
	logic [6:0] o_file_addr;
	int failures = 0, comparisons = 0, cycles = 0;
	bit_test_call_clear_exec dut (.*);
	initial forever #25 i_ref_clk = ~i_ref_clk;
	task automatic print_verdict;
		if (failures == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic cmp(input string n, input logic [12:0] e, input logic [12:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	// one instruction per call, taken at the next edge, looked at just after it
	task automatic step(input logic [13:0] w, input logic [7:0] f, input logic v);
		i_insn <= w;
		i_file_rdata <= f;
		i_insn_valid <= v;
		@(posedge i_ref_clk);
		#1;
	endtask
	task automatic t_and;
		step(OP_AND_FILE | 14'h00aa, 8'hff, 1'b1);
		cmp("and we", 13'h0001, o_file_we);
		cmp("and wdata", 13'h0000, o_file_wdata);
		cmp("and status", 13'h001c, o_status);
		cmp("and taken", 13'h0001, o_insn_taken);
		step(OP_AND_FILE | 14'h002a, 8'hff, 1'b1);
		cmp("and acc we", 13'h0000, o_file_we);
		cmp("and acc", 13'h0000, o_acc);
		cmp("and acc addr", 13'h002a, o_file_addr);
	endtask
	task automatic t_call;
		logic [12:0] p;
		p = o_pc;
		step(14'h2123, 8'h00, 1'b1);
		cmp("call pc", 13'h1923, o_pc);
		cmp("call flush", 13'h0001, o_flush);
		step(OP_ZERO_FILE | 14'h0005, 8'h00, 1'b1);
		cmp("nop we", 13'h0000, o_file_we);
		cmp("nop pc", 13'h1924, o_pc);
		cmp("stack top", p + 13'h0001, o_stack_top_entry);
	endtask
	task automatic t_skip;
		logic b;
		for (int i = 0; i < 4; i++) begin
			b = i[0];
			step((i[1] ? OP_BIT_SET : OP_BIT_CLEAR) | 14'h0280, b ? 8'h20 : 8'hdf, 1'b1);
			cmp("skip", {12'h000, i[0] == i[1]}, o_flush);
			step(14'h0000, 8'h00, 1'b1);
		end
	endtask
	task automatic t_clr;
		step(OP_ZERO_FILE | 14'h0055, 8'hff, 1'b1);
		cmp("zero_file_reg_op we", 13'h0001, o_file_we);
		cmp("zero_file_reg_op addr", 13'h0055, o_file_addr);
		cmp("zero_file_reg_op wdata", 13'h0000, o_file_wdata);
		cmp("zero_file_reg_op zero", 13'h0001, o_status[ST_ZERO]);
		step(OP_ZERO_ACC, 8'hff, 1'b1);
		cmp("zero_acc_op acc", 13'h0000, o_acc);
	endtask
	task automatic t_wdt;
		repeat (600) begin
			i_wdt_tick <= ~i_wdt_tick;
			step(14'h0000, 8'h00, 1'b0);
		end
		cmp("wdt count", 13'h0001, o_watchdog_count);
		cmp("wdt pre", 13'h002c, o_wdt_prescale);
		cmp("idle taken", 13'h0000, o_insn_taken);
		i_wdt_tick <= 1'b1;
		step(OP_WDT_RESTART, 8'h00, 1'b1);
		cmp("restart count", 13'h0000, o_watchdog_count);
		cmp("restart pre", 13'h0000, o_wdt_prescale);
		cmp("restart status", 13'h0003, o_status[4:3]);
	endtask
	initial begin
		repeat (20) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		#1;
		cmp("reset status", 13'h0018, o_status);
		t_and;
		t_call;
		t_skip;
		t_clr;
		t_wdt;
		print_verdict;
	end
	always @(posedge i_ref_clk) begin
		cycles++;
		if (cycles == 2000) begin
			failures++;
			print_verdict;
		end
	end
endmodule
